// ===== common/nibble_alu_pkg.sv
/*
 * Shared constants for the nibble datapath: instruction codes and masks,
 * immediate field positions, reset values and the decoded operation type.
 * Assumes a 10-bit instruction word and 4-bit data memory.
 */
package nibble_alu_pkg;

    // word and field positions
    localparam int WORD_W = 10;
    localparam int J_MSB = 1;
    localparam int N_MSB = 3;
    localparam int P_MSB = 5;

    // masks that strip the immediate field before comparing
    localparam logic [9:0] MASK_J = 10'h3FC;
    localparam logic [9:0] MASK_N = 10'h3F0;
    localparam logic [9:0] MASK_P = 10'h3C0;
    localparam logic [9:0] MASK_F = 10'h3FF;

    // instruction codes with immediate fields zeroed
    localparam logic [9:0] CODE_SETBIT = 10'h05C;
    localparam logic [9:0] CODE_CLRBIT = 10'h04C;
    localparam logic [9:0] CODE_SKZBIT = 10'h020;
    localparam logic [9:0] CODE_SKEQM = 10'h026;
    localparam logic [9:0] CODE_SKEQI = 10'h025;
    localparam logic [9:0] CODE_LOADI = 10'h070;
    localparam logic [9:0] CODE_TABLE = 10'h080;
    localparam logic [9:0] CODE_ADDM = 10'h00A;
    localparam logic [9:0] CODE_ADDMC = 10'h00B;
    localparam logic [9:0] CODE_ADDI = 10'h060;
    localparam logic [9:0] CODE_AND = 10'h018;
    localparam logic [9:0] CODE_OR = 10'h019;
    localparam logic [9:0] CODE_SETC = 10'h007;
    localparam logic [9:0] CODE_CLRC = 10'h006;
    localparam logic [9:0] CODE_SKNC = 10'h02F;
    localparam logic [9:0] CODE_CPL = 10'h01C;
    localparam logic [9:0] CODE_ROTR = 10'h01D;

    // reset values
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic [3:0] B_RST = 4'h0;
    localparam logic CARRY_RST = 1'b0;

    typedef enum {
        K_NONE, K_SETBIT, K_CLRBIT, K_SKZBIT, K_SKEQM, K_SKEQI, K_LOADI, K_TABLE,
        K_ADDM, K_ADDMC, K_ADDI, K_AND, K_OR, K_SETC, K_CLRC, K_SKNC, K_CPL, K_ROTR
    } op_type;

    // decode one instruction word; unknown words map to K_NONE
    function automatic op_type decode(input logic [9:0] w);
        op_type k;
        k = K_NONE;
        if ((w & MASK_J) == CODE_SETBIT) k = K_SETBIT;
        else if ((w & MASK_J) == CODE_CLRBIT) k = K_CLRBIT;
        else if ((w & MASK_J) == CODE_SKZBIT) k = K_SKZBIT;
        else if ((w & MASK_F) == CODE_SKEQM) k = K_SKEQM;
        else if ((w & MASK_F) == CODE_SKEQI) k = K_SKEQI;
        else if ((w & MASK_N) == CODE_LOADI) k = K_LOADI;
        else if ((w & MASK_P) == CODE_TABLE) k = K_TABLE;
        else if ((w & MASK_F) == CODE_ADDM) k = K_ADDM;
        else if ((w & MASK_F) == CODE_ADDMC) k = K_ADDMC;
        else if ((w & MASK_N) == CODE_ADDI) k = K_ADDI;
        else if ((w & MASK_F) == CODE_AND) k = K_AND;
        else if ((w & MASK_F) == CODE_OR) k = K_OR;
        else if ((w & MASK_F) == CODE_SETC) k = K_SETC;
        else if ((w & MASK_F) == CODE_CLRC) k = K_CLRC;
        else if ((w & MASK_F) == CODE_SKNC) k = K_SKNC;
        else if ((w & MASK_F) == CODE_CPL) k = K_CPL;
        else if ((w & MASK_F) == CODE_ROTR) k = K_ROTR;
        return k;
    endfunction : decode

endpackage : nibble_alu_pkg

// ===== rtl/memory_bit_unit.sv
/*
 * Bit set, clear and test on one data-memory nibble.
 * Assumes mem is the nibble currently addressed by the memory pointer.
 */
`timescale 1ns/1ps
module memory_bit_unit (
    input logic [3:0] mem,
    input logic [1:0] sel,
    input logic setBit,
    output logic [3:0] wrData,
    output logic bitValue
);
    logic [3:0] mask;

    // only the selected bit changes; the others are written back as read
    assign mask = 4'h1 << sel;
    assign wrData = setBit ? (mem | mask) : (mem & ~mask);
    assign bitValue = mem[sel];

endmodule : memory_bit_unit

// ===== rtl/nibble_alu_bit_compare_skip.sv
/*
 * Execution datapath: accumulator, register B, carry, bit operations,
 * comparisons, ROM table fetch and the skip of the next instruction.
 * Assumes the sequencer presents one instruction word per cycle with
 * instrValid, holds off while busy_reg is high, keeps the memory pointer
 * steady for the cycle after a memory write, owns the stack and program
 * counter, and that ROM answers one cycle after romRead_reg.
 */
`timescale 1ns/1ps

module nibble_alu_bit_compare_skip
    import nibble_alu_pkg::*;
(
    input logic mclk,
    input logic rst_n,
    input logic instrValid,
    input logic [9:0] instrWord,
    input logic [3:0] memRdData,
    input logic [2:0] tableHigh,
    input logic [7:0] romData,
    output logic [3:0] acc_reg,
    output logic [3:0] regB_reg,
    output logic carry_reg,
    output logic skip_reg,
    output logic memWrEn_reg,
    output logic [3:0] memWrData_reg,
    output logic romRead_reg,
    output logic [12:0] romAddr_reg,
    output logic stackPush_reg,
    output logic stackPop_reg,
    output logic busy_reg
);
    typedef enum {ST_RUN, ST_SEA_IMM, ST_TAB_READ, ST_TAB_LOAD} state_type;

    state_type state_reg;
    op_type op;
    logic take;
    logic seaWord;
    logic suppress;
    logic exec;
    logic skipCond;
    logic loadChain_reg;
    logic seaDrop_reg;
    logic [3:0] aluAcc;
    logic aluCarry;
    logic aluOvf;
    logic aluWrA;
    logic [3:0] bitWr;
    logic bitVal;

    // decode and issue qualification
    assign op = decode(instrWord);
    assign take = instrValid && (state_reg == ST_RUN);
    assign seaWord = instrValid && (state_reg == ST_SEA_IMM);
    assign suppress = skip_reg || (loadChain_reg && op == K_LOADI);
    assign exec = take && !suppress;

    nibble_alu_core u_alu (
        .op(op),
        .acc(acc_reg),
        .mem(memRdData),
        .carry(carry_reg),
        .imm(instrWord[N_MSB:0]),
        .accNext(aluAcc),
        .carryNext(aluCarry),
        .carryOut(aluOvf),
        .writesAcc(aluWrA)
    );

    memory_bit_unit u_bit (
        .mem(memRdData),
        .sel(instrWord[J_MSB:0]),
        .setBit(op == K_SETBIT),
        .wrData(bitWr),
        .bitValue(bitVal)
    );

    // skip conditions of single-word tests
    always_comb begin
        case (op)
            K_SKZBIT: skipCond = !bitVal;
            K_SKEQM: skipCond = (acc_reg == memRdData);
            K_ADDI: skipCond = !aluOvf;
            K_SKNC: skipCond = !carry_reg;
            default: skipCond = 1'b0;
        endcase
    end

    // sequencing of two-word compare and three-cycle table fetch
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (take && op == K_SKEQI) begin
                        state_reg <= ST_SEA_IMM;
                    end else if (exec && op == K_TABLE) begin
                        state_reg <= ST_TAB_READ;
                    end
                end
                ST_SEA_IMM: begin
                    if (instrValid) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_TAB_READ: state_reg <= ST_TAB_LOAD;
                ST_TAB_LOAD: state_reg <= ST_RUN;
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // a skipped compare must also swallow its immediate word
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            seaDrop_reg <= 1'b0;
        end else if (take && op == K_SKEQI) begin
            seaDrop_reg <= suppress;
        end
    end

    // skip request: set by a test, consumed by the next word
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            skip_reg <= 1'b0;
        end else if (take) begin
            skip_reg <= exec && skipCond;
        end else if (seaWord) begin
            skip_reg <= !seaDrop_reg && (acc_reg == instrWord[N_MSB:0]);
        end
    end

    // remembers that the previous word was a load immediate
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            loadChain_reg <= 1'b0;
        end else if (take) begin
            loadChain_reg <= (op == K_LOADI);
        end
    end

    // accumulator
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            acc_reg <= ACC_RST;
        end else if (state_reg == ST_TAB_LOAD) begin
            acc_reg <= romData[3:0];
        end else if (exec && op == K_LOADI) begin
            acc_reg <= instrWord[N_MSB:0];
        end else if (exec && aluWrA) begin
            acc_reg <= aluAcc;
        end
    end

    // carry flag; the alu passes it through for operations that keep it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            carry_reg <= CARRY_RST;
        end else if (exec) begin
            carry_reg <= aluCarry;
        end
    end

    // register B only changes on a table fetch
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            regB_reg <= B_RST;
        end else if (state_reg == ST_TAB_LOAD) begin
            regB_reg <= romData[7:4];
        end
    end

    // memory write is issued a cycle late, as a full nibble
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            memWrEn_reg <= 1'b0;
            memWrData_reg <= 4'h0;
        end else begin
            memWrEn_reg <= exec && (op == K_SETBIT || op == K_CLRBIT);
            memWrData_reg <= bitWr;
        end
    end

    // ROM table request: page, high bits and accumulator
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            romRead_reg <= 1'b0;
            romAddr_reg <= 13'h0000;
        end else begin
            romRead_reg <= exec && op == K_TABLE;
            if (exec && op == K_TABLE) begin
                romAddr_reg <= {instrWord[P_MSB:0], tableHigh, acc_reg};
            end
        end
    end

    // stack level held for the fetch, released when data lands
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stackPush_reg <= 1'b0;
            stackPop_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            stackPush_reg <= exec && op == K_TABLE;
            stackPop_reg <= (state_reg == ST_TAB_LOAD);
            busy_reg <= (exec && op == K_TABLE) || (state_reg == ST_TAB_READ);
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    setBit_a: assert property (
        exec && op == K_SETBIT |=> memWrEn_reg
            && memWrData_reg == ($past(memRdData) | (4'h1 << $past(instrWord[1:0]))))
        else $error("set bit wrote wrong nibble");

    clearBit_a: assert property (
        exec && op == K_CLRBIT |=> memWrEn_reg
            && memWrData_reg == ($past(memRdData) & ~(4'h1 << $past(instrWord[1:0]))))
        else $error("clear bit wrote wrong nibble");

    zeroBit_a: assert property (
        exec && op == K_SKZBIT |=> skip_reg == !$past(bitVal) && !memWrEn_reg)
        else $error("zero bit skip wrong");

    memEqual_a: assert property (
        exec && op == K_SKEQM |=> skip_reg == ($past(acc_reg) == $past(memRdData)))
        else $error("memory compare skip wrong");

    immEqual_a: assert property (
        seaWord && !seaDrop_reg |=> skip_reg == ($past(acc_reg) == $past(instrWord[3:0])))
        else $error("immediate compare skip wrong");

    // a swallowed immediate word must never raise a skip
    immDrop_a: assert property (
        seaWord && seaDrop_reg |=> !skip_reg && $stable(acc_reg))
        else $error("swallowed immediate word acted");

    loadChain_a: assert property (
        take && op == K_LOADI && loadChain_reg |=> $stable(acc_reg))
        else $error("chained load executed");

    tableLoad_a: assert property (
        exec && op == K_TABLE |=> romRead_reg ##2
            acc_reg == $past(romData[3:0]) && regB_reg == $past(romData[7:4]))
        else $error("table fetch loaded wrong data");

    tableStack_a: assert property (
        exec && op == K_TABLE |=> stackPush_reg && busy_reg ##1 busy_reg ##1 stackPop_reg)
        else $error("table fetch stack use wrong");

    addImm_a: assert property (
        exec && op == K_ADDI |=> skip_reg == !$past(aluOvf) && $stable(carry_reg))
        else $error("immediate add skip or carry wrong");

    skipNull_a: assert property (
        take && skip_reg |=> $stable(acc_reg) && $stable(carry_reg) && !memWrEn_reg && !romRead_reg)
        else $error("skipped word changed state");

    tableDone_c: cover property (exec && op == K_TABLE ##3 stackPop_reg);
    immSkip_c: cover property (seaWord && !seaDrop_reg ##1 skip_reg);
    chainLoad_c: cover property (take && op == K_LOADI ##1 take && op == K_LOADI);

endmodule : nibble_alu_bit_compare_skip

// ===== rtl/nibble_alu_core.sv
/*
 * Combinational accumulator arithmetic and logic unit.
 * Assumes the caller decides whether the results are committed.
 */
`timescale 1ns/1ps
module nibble_alu_core
    import nibble_alu_pkg::*;
(
    input op_type op,
    input logic [3:0] acc,
    input logic [3:0] mem,
    input logic carry,
    input logic [3:0] imm,
    output logic [3:0] accNext,
    output logic carryNext,
    output logic carryOut,
    output logic writesAcc
);
    logic [4:0] sum;

    // carry is passed through unless the operation owns it
    always_comb begin
        sum = 5'h00;
        accNext = acc;
        carryNext = carry;
        writesAcc = 1'b0;
        case (op)
            K_ADDM: begin
                sum = {1'b0, acc} + {1'b0, mem};
                accNext = sum[3:0];
                writesAcc = 1'b1;
            end
            K_ADDMC: begin
                sum = {1'b0, acc} + {1'b0, mem} + {4'h0, carry};
                accNext = sum[3:0];
                carryNext = sum[4];
                writesAcc = 1'b1;
            end
            K_ADDI: begin
                sum = {1'b0, acc} + {1'b0, imm};
                accNext = sum[3:0];
                writesAcc = 1'b1;
            end
            K_AND: begin
                accNext = acc & mem;
                writesAcc = 1'b1;
            end
            K_OR: begin
                accNext = acc | mem;
                writesAcc = 1'b1;
            end
            K_CPL: begin
                accNext = ~acc;
                writesAcc = 1'b1;
            end
            K_ROTR: begin
                accNext = {carry, acc[3:1]};
                carryNext = acc[0];
                writesAcc = 1'b1;
            end
            K_SETC: carryNext = 1'b1;
            K_CLRC: carryNext = 1'b0;
            default: sum = 5'h00;
        endcase
    end

    // overflow of the last addition, used by the immediate add skip
    assign carryOut = sum[4];

endmodule : nibble_alu_core

// ===== test/nibble_alu_bit_compare_skip_tb.sv
/*
 * Self-checking bench for the nibble datapath, one task per scenario.
 * Assumes the memory model answers for RAM and ROM.
 */
`timescale 1ns/1ps
module nibble_alu_bit_compare_skip_tb;
    import nibble_alu_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic instrValid = 1'b0;
    logic [9:0] instrWord = 10'h000;
    logic [2:0] tableHigh = 3'h0;
    logic [3:0] ptr = 4'h0;
    logic [3:0] memRdData, acc_reg, regB_reg, memWrData_reg;
    logic [7:0] romData;
    logic [12:0] romAddr_reg;
    logic carry_reg, skip_reg, memWrEn_reg, romRead_reg;
    logic stackPush_reg, stackPop_reg, busy_reg;
    int num_errors = 0;
    int compares = 0;

    always #2 mclk = ~mclk;

    nibble_alu_bit_compare_skip dut (.mclk(mclk), .rst_n(rst_n),
        .instrValid(instrValid), .instrWord(instrWord), .memRdData(memRdData),
        .tableHigh(tableHigh), .romData(romData), .acc_reg(acc_reg),
        .regB_reg(regB_reg), .carry_reg(carry_reg), .skip_reg(skip_reg),
        .memWrEn_reg(memWrEn_reg), .memWrData_reg(memWrData_reg),
        .romRead_reg(romRead_reg), .romAddr_reg(romAddr_reg),
        .stackPush_reg(stackPush_reg), .stackPop_reg(stackPop_reg),
        .busy_reg(busy_reg));

    nibble_mem_model mem (.mclk(mclk), .memPtr(ptr), .memWrEn(memWrEn_reg),
        .memWrData(memWrData_reg), .memRdData(memRdData), .romRead(romRead_reg),
        .romAddr(romAddr_reg), .romData(romData));

    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // present one word; results of that edge have landed on return
    task automatic step(input logic [9:0] w);
        instrValid = 1'b1;
        instrWord = w;
        @(posedge mclk);
        #1;
    endtask : step

    task automatic idle;
        instrValid = 1'b0;
        @(posedge mclk);
        #1;
    endtask : idle

    function automatic logic [9:0] wi(input logic [9:0] c, input logic [3:0] n);
        return c | {6'h00, n};
    endfunction : wi

    task automatic t_reset;
        chk({acc_reg, regB_reg, carry_reg, skip_reg}, 13'h0, "reset regs");
        chk({memWrEn_reg, romRead_reg, stackPush_reg, stackPop_reg, busy_reg}, 13'h0, "rst out");
    endtask : t_reset

    // bit set, clear and test, with a suppressed word after each skip
    task automatic t_bits;
        logic [3:0] e;
        ptr = 4'h0;
        e = 4'h0;
        step(CODE_CLRC);
        for (int j = 0; j < 4; j++) begin
            step(CODE_SETBIT | 10'(j));
            e = e | (4'h1 << j);
            chk(memWrEn_reg, 1, "set en");
            chk(memWrData_reg, e, "set data");
            step(CODE_SKZBIT | 10'(j));
            chk({memWrEn_reg, skip_reg}, 0, "test one");
        end
        for (int j = 0; j < 4; j++) begin
            step(CODE_CLRBIT | 10'(j));
            e = e & ~(4'h1 << j);
            chk(memWrData_reg, e, "clr data");
            step(CODE_SKZBIT | 10'(j));
            chk(skip_reg, 1, "test zero");
            step(CODE_SETC);
            chk({carry_reg, skip_reg}, 0, "suppressed");
        end
    endtask : t_bits

    task automatic t_compare;
        ptr = 4'h3;
        step(wi(CODE_LOADI, 4'h3));
        step(CODE_SKEQM);
        chk(skip_reg, 1, "eq mem");
        step(CODE_CPL);
        chk(acc_reg, 4'h3, "skipped cpl");
        ptr = 4'h4;
        step(CODE_SKEQM);
        chk(skip_reg, 0, "ne mem");
        for (int n = 3; n < 5; n++) begin
            step(CODE_SKEQI);
            step(wi(CODE_LOADI, 4'(n)));
            chk(skip_reg, 13'(n == 3), "eq imm");
            chk(acc_reg, 4'h3, "imm word");
            step(10'h000);
        end
        // skipped compare swallows its immediate, which would match here
        step(CODE_SKNC);
        step(CODE_SKEQI);
        step(wi(CODE_LOADI, 4'h3));
        chk({acc_reg, skip_reg}, 13'h006, "swallowed imm");
        step(CODE_SETC);
        chk(carry_reg, 1, "setc");
        step(CODE_SKNC);
        chk({carry_reg, skip_reg}, 2, "carry set");
        step(CODE_CLRC);
        chk(carry_reg, 0, "clrc");
        step(CODE_SKNC);
        chk({carry_reg, skip_reg}, 1, "carry clr");
        step(CODE_SETC);
        chk(carry_reg, 0, "skipped setc");
    endtask : t_compare

    task automatic t_loads;
        step(wi(CODE_LOADI, 4'h5));
        step(wi(CODE_LOADI, 4'h9));
        step(wi(CODE_LOADI, 4'h7));
        chk(acc_reg, 4'h5, "load chain");
        step(CODE_CPL);
        chk(acc_reg, 4'hA, "cpl");
        step(wi(CODE_LOADI, 4'h9));
        chk(acc_reg, 4'h9, "load again");
    endtask : t_loads

    // each row: word, then expected accumulator, carry and skip
    task automatic t_arith;
        logic [9:0] w [16];
        logic [5:0] x [16];
        ptr = 4'h6;
        w = '{CODE_CLRC, wi(CODE_LOADI, 4'hC), CODE_ADDM, CODE_SETC, CODE_ADDM,
              CODE_ADDMC, CODE_ADDMC, wi(CODE_ADDI, 4'hB), wi(CODE_ADDI, 4'h1),
              CODE_CPL, CODE_AND, CODE_OR, CODE_CPL, CODE_ROTR, CODE_ROTR, CODE_ROTR};
        x = '{6'h24, 6'h30, 6'h08, 6'h0A, 6'h22, 6'h3C, 6'h16, 6'h02, 6'h07,
              6'h06, 6'h02, 6'h1A, 6'h26, 6'h32, 6'h38, 6'h1C};
        for (int i = 0; i < 16; i++) begin
            step(w[i]);
            chk({acc_reg, carry_reg, skip_reg}, x[i], "arith");
        end
    endtask : t_arith

    task automatic t_table;
        tableHigh = 3'h5;
        step(CODE_SKNC);
        step(CODE_TABLE | 10'h02B);
        chk({romRead_reg, stackPush_reg, busy_reg}, 0, "skipped fetch");
        step(CODE_TABLE | 10'h02B);
        chk({romRead_reg, stackPush_reg, busy_reg}, 7, "fetch issue");
        chk(romAddr_reg, {6'h2B, 3'h5, 4'h7}, "rom addr");
        step(CODE_SETC);
        chk({romRead_reg, stackPush_reg, busy_reg, carry_reg}, 2, "busy");
        idle();
        chk({regB_reg, acc_reg}, 8'h8D, "fetch data");
        chk({stackPop_reg, busy_reg}, 2, "restore");
        step(CODE_SETC);
        chk({stackPop_reg, carry_reg}, 1, "after fetch");
        idle();
    endtask : t_table

    initial begin
        #20000;
        num_errors++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_bits();
        t_compare();
        t_loads();
        t_arith();
        t_table();
        test_done();
    end
endmodule : nibble_alu_bit_compare_skip_tb

// ===== test/nibble_mem_model.sv
/*
 * Far-side model: nibble data RAM with combinational read and ROM
 * answering one cycle after a read request.
 * Assumes the bench owns the memory pointer and keeps it steady.
 */
`timescale 1ns/1ps
module nibble_mem_model (
    input logic mclk,
    input logic [3:0] memPtr,
    input logic memWrEn,
    input logic [3:0] memWrData,
    output logic [3:0] memRdData,
    input logic romRead,
    input logic [12:0] romAddr,
    output logic [7:0] romData
);
    logic [3:0] ram [16];

    // each nibble starts equal to its own address
    initial begin
        for (int i = 0; i < 16; i++) ram[i] = 4'(i);
        romData = 8'h00;
    end

    // write lands at the edge; bypass keeps the read write-first
    always @(posedge mclk) begin
        if (memWrEn) ram[memPtr] <= memWrData;
    end
    assign memRdData = memWrEn ? memWrData : ram[memPtr];

    // rom pattern from address; outside a read the bus toggles
    always @(posedge mclk) begin
        if (romRead) romData <= romAddr[7:0] ^ 8'h5A;
        else romData <= ~romData;
    end
endmodule : nibble_mem_model
